// >>> hdl/wwd_cnt.sv
// module: wrap counter, paused while run_i is low, giving a one-cycle tick
`timescale 1ns/1ps
module wwd_cnt
    import wwd_pkg::*;
#(
    parameter int WIDTH = 14,
    parameter int LIMIT = 12288
) (
    // clock and reset
    input  wire logic mclk_i,
    input  wire logic arst_n_i,
    // control
    input  wire logic run_i,
    output logic      tick_o
);
    // refuse a limit that the counter cannot reach
    if (LIMIT < 2 || LIMIT > (1 << WIDTH)) begin : g_bad_limit
        $error("wwd_cnt: LIMIT does not fit WIDTH");
    end

    typedef struct packed {
        logic [WIDTH-1:0] cnt;
    } wwd_cnt_st_t;

    wwd_cnt_st_t st_reg;
    wwd_cnt_st_t st_next;

    localparam logic [WIDTH-1:0] LAST = WIDTH'(LIMIT - 1);

    // wrap at LIMIT; never cleared by software writes
    always_comb begin
        st_next = st_reg;
        if (run_i) begin
            if (st_reg.cnt == LAST)
                st_next.cnt = '0;
            else
                st_next.cnt = st_reg.cnt + WIDTH'(1);
        end
    end

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i)
            st_reg <= '0;
        else
            st_reg <= st_next;
    end

    assign tick_o = run_i && (st_reg.cnt == LAST);
endmodule

// >>> hdl/wwd_pkg.sv
// package: constants and types for the windowed watchdog timer
//
// Overview of operation
// - counter drops by one each time the 12288-cycle prescaler expires
// - active and count falls 40h to 3Fh: reset pin pulled low ~500ns
// - six low written bits set prescaler steps left before reset
// - disabled after any reset; once active only reset disables it
// - write with activation set and msb clear forces a reset
// - halt while active resets, when the halt option selects it
// - hardware option keeps watchdog always active, activation bit ignored
// - at 8MHz C0h times out within 1.536ms, FFh 96.768-98.304ms
// - activation bit is bit 7, software-set, reset-cleared; reset 7Fh
// - after halt without reset, counting resumes 4096 clocks after wake
package wwd_pkg;

    // ------------------------------------------------------------------
    // register map
    // ------------------------------------------------------------------
    localparam logic [11:0] WWD_CTRL_OFS   = 12'h000;
    localparam logic [11:0] WWD_STAT_OFS   = 12'h004;
    localparam logic [7:0]  WWD_CTRL_RST   = 8'h7F;
    localparam int          WWD_ACT_BIT    = 7;
    localparam int          WWD_MSB_BIT    = 6;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int          WWD_CLK_PS     = 5000;
    localparam int          WWD_PRESC_CYC  = 12288;
    localparam int          WWD_RST_NS     = 500;
    localparam int          WWD_RST_CYC    = (WWD_RST_NS * 1000) / WWD_CLK_PS;
    localparam int          WWD_WAKE_CYC   = 4096;

    // halt handling state
    typedef enum logic [1:0] {
        WWD_RUN,
        WWD_HALTED,
        WWD_WAKING
    } wwd_mode_t;

    // apb request carrier
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } wwd_apb_req_t;

endpackage

// >>> hdl/wwd_top.sv
// module: windowed watchdog timer with apb control register
//
// The APB slave port and the register addresses were left to the implementer.
`timescale 1ns/1ps
module wwd_top
    import wwd_pkg::*;
#(
    parameter int PRESC_CYC = WWD_PRESC_CYC,
    parameter int WAKE_CYC  = WWD_WAKE_CYC
) (
    // clock and reset
    input  wire logic        mclk_i,
    input  wire logic        arst_n_i,
    // apb slave
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [11:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic [31:0]      prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    // option byte and cpu status
    input  wire logic        hw_watchdog_i,
    input  wire logic        halt_reset_option_i,
    input  wire logic        halt_i,
    input  wire logic        wake_i,
    // reset request
    output logic             wdg_reset_n_o
);
    // refuse settings that the counters cannot serve
    if (PRESC_CYC < 2 || PRESC_CYC > 16384) begin : g_bad_presc
        $error("wwd_top: PRESC_CYC out of range");
    end
    if (WAKE_CYC < 1 || WAKE_CYC > 65535) begin : g_bad_wake
        $error("wwd_top: WAKE_CYC out of range");
    end
    // pulse counter is seven bits; the pulse check needs nine cycles
    if (WWD_RST_CYC < 9 || WWD_RST_CYC > 128) begin : g_bad_pulse
        $error("wwd_top: WWD_RST_CYC out of range");
    end

    localparam logic [6:0]  RST_LAST   = 7'(WWD_RST_CYC - 1);
    localparam logic [15:0] WAKE_LAST  = 16'(WAKE_CYC - 1);
    localparam int          PULSE_TAIL = WWD_RST_CYC - 8;

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic        activation_bit;
        logic [6:0]  count_value;
        wwd_mode_t   mode;
        logic [15:0] wake_cnt;
        logic        rst_busy;
        logic [6:0]  rst_cnt;
        logic [31:0] prdata;
    } wwd_st_t;

    wwd_st_t      st_reg;
    wwd_st_t      st_next;
    wwd_apb_req_t req;
    logic         tick;
    logic         active;
    logic         wr_ctrl;
    logic         rd_acc;
    logic         addr_ok;
    logic         counting;
    logic         fire;

    assign req = '{psel: psel_i, penable: penable_i, pwrite: pwrite_i,
                   paddr: paddr_i, pwdata: pwdata_i};

    // prescaler stops while halted or waking
    assign counting = (st_reg.mode == WWD_RUN);

    // free prescaler, never restarted by a refresh
    wwd_cnt #(
        .WIDTH (14),
        .LIMIT (PRESC_CYC)
    ) i_wwd_cnt (
        .mclk_i   (mclk_i),
        .arst_n_i (arst_n_i),
        .run_i    (counting),
        .tick_o   (tick)
    );

    // ------------------------------------------------------------------
    // bus decode: zero wait states
    // ------------------------------------------------------------------
    assign addr_ok = (req.paddr == WWD_CTRL_OFS) ||
                     (req.paddr == WWD_STAT_OFS);
    assign wr_ctrl = req.psel && req.penable && req.pwrite &&
                     (req.paddr == WWD_CTRL_OFS);
    assign rd_acc  = req.psel && !req.penable && !req.pwrite;
    assign pready_o  = 1'b1;
    assign pslverr_o = req.psel && req.penable && !addr_ok;
    assign prdata_o  = st_reg.prdata;

    // hardware option overrides the activation bit
    assign active = st_reg.activation_bit || hw_watchdog_i;

    // any reset reason this cycle
    always_comb begin
        fire = 1'b0;
        if (active && tick && st_reg.count_value == 7'h40)
            fire = 1'b1;
        if (wr_ctrl && req.pwdata[WWD_ACT_BIT] && !req.pwdata[WWD_MSB_BIT])
            fire = 1'b1;
        if (active && halt_i && halt_reset_option_i &&
            st_reg.mode == WWD_RUN)
            fire = 1'b1;
    end

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        st_next = st_reg;
        if (tick)
            st_next.count_value = st_reg.count_value - 7'h01;
        // refresh; activation is sticky, only reset clears it
        if (wr_ctrl) begin
            st_next.count_value = req.pwdata[6:0];
            if (req.pwdata[WWD_ACT_BIT])
                st_next.activation_bit = 1'b1;
        end
        // halt without reset: freeze, then delayed resume
        unique case (st_reg.mode)
            WWD_RUN: begin
                if (halt_i && !halt_reset_option_i)
                    st_next.mode = WWD_HALTED;
            end
            WWD_HALTED: begin
                if (wake_i) begin
                    st_next.mode     = WWD_WAKING;
                    st_next.wake_cnt = '0;
                end
            end
            WWD_WAKING: begin
                st_next.wake_cnt = st_reg.wake_cnt + 16'h0001;
                if (st_reg.wake_cnt == WAKE_LAST)
                    st_next.mode = WWD_RUN;
            end
        endcase
        // reset pulse of fixed length
        if (st_reg.rst_busy) begin
            st_next.rst_cnt = st_reg.rst_cnt + 7'h01;
            if (st_reg.rst_cnt == RST_LAST)
                st_next.rst_busy = 1'b0;
        end else if (fire) begin
            st_next.rst_busy = 1'b1;
            st_next.rst_cnt  = '0;
        end
        // read data captured in setup so it is stable in access
        if (rd_acc) begin
            if (req.paddr == WWD_CTRL_OFS)
                st_next.prdata = {24'h000000, st_reg.activation_bit,
                                  st_reg.count_value};
            else if (req.paddr == WWD_STAT_OFS)
                st_next.prdata = {28'h0000000, active, st_reg.rst_busy,
                                  st_reg.mode};
            else
                st_next.prdata = '0;
        end
    end

    // device reset re-enters via arst_n_i, disabling the watchdog unless hw_watchdog_i is set
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            st_reg                <= '0;
            st_reg.count_value    <= WWD_CTRL_RST[6:0];
            st_reg.activation_bit <= 1'b0;
            st_reg.mode           <= WWD_RUN;
        end else begin
            st_reg <= st_next;
        end
    end

    assign wdg_reset_n_o = !st_reg.rst_busy;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!arst_n_i);

    sequence s_pulse_start;
        !st_reg.rst_busy && fire;
    endsequence

    property p_rollover_reset;
        active && tick && st_reg.count_value == 7'h40 && !st_reg.rst_busy
            |=> !wdg_reset_n_o;
    endproperty
    a_rollover_reset: assert property (p_rollover_reset)
        else $error("rollover did not start reset");

    property p_pulse_len;
        s_pulse_start |=> (!wdg_reset_n_o) [*8] ##PULSE_TAIL (!wdg_reset_n_o)
            ##1 wdg_reset_n_o;
    endproperty
    a_pulse_len: assert property (p_pulse_len)
        else $error("reset pulse length wrong");

    property p_decrement;
        tick && !wr_ctrl |=> st_reg.count_value ==
            $past(st_reg.count_value) - 7'h01;
    endproperty
    a_decrement: assert property (p_decrement)
        else $error("count did not decrement on tick");

    property p_load;
        wr_ctrl |=> st_reg.count_value == $past(req.pwdata[6:0]);
    endproperty
    a_load: assert property (p_load)
        else $error("write did not load count");

    property p_sticky;
        st_reg.activation_bit |=> st_reg.activation_bit;
    endproperty
    a_sticky: assert property (p_sticky)
        else $error("activation bit cleared without reset");

    property p_sw_reset;
        wr_ctrl && req.pwdata[7:6] == 2'b10 && !st_reg.rst_busy
            |=> !wdg_reset_n_o;
    endproperty
    a_sw_reset: assert property (p_sw_reset)
        else $error("software reset write ignored");

    property p_halt_reset;
        active && halt_i && halt_reset_option_i && counting &&
            !st_reg.rst_busy |=> !wdg_reset_n_o;
    endproperty
    a_halt_reset: assert property (p_halt_reset)
        else $error("halt while active did not reset");

    property p_hw_active;
        hw_watchdog_i && !st_reg.activation_bit && tick &&
            st_reg.count_value == 7'h40 && !st_reg.rst_busy
            |=> !wdg_reset_n_o;
    endproperty
    a_hw_active: assert property (p_hw_active)
        else $error("hardware option not forcing active");

    property p_frozen;
        st_reg.mode != WWD_RUN && !wr_ctrl |=> $stable(st_reg.count_value);
    endproperty
    a_frozen: assert property (p_frozen)
        else $error("counting while halted or waking");
endmodule

// >>> verif/wwd_top_test.sv
// testbench: apb-driven checks of the windowed watchdog timer
`timescale 1ns/1ps
module wwd_top_test;
    import wwd_pkg::*;

    // short counts keep the run small
    localparam int PC = 16;
    localparam int WC = 8;

    logic        mclk_i              = 1'b0;
    logic        arst_n_i            = 1'b0;
    logic        psel_i              = 1'b0;
    logic        penable_i           = 1'b0;
    logic        pwrite_i            = 1'b0;
    logic [11:0] paddr_i             = 12'h000;
    logic [31:0] pwdata_i            = 32'h00000000;
    logic [31:0] prdata_o;
    logic        pready_o;
    logic        pslverr_o;
    logic        hw_watchdog_i       = 1'b0;
    logic        halt_reset_option_i = 1'b0;
    logic        halt_i              = 1'b0;
    logic        wake_i              = 1'b0;
    logic        wdg_reset_n_o;
    int          num_errors          = 0;
    int          num_checks          = 0;
    int          cyc                 = 0;
    int          tf, tw, t1, len;
    logic [31:0] rd, v;
    logic        er;

    wwd_top #(.PRESC_CYC(PC), .WAKE_CYC(WC)) i_wwd_top (
        .mclk_i(mclk_i), .arst_n_i(arst_n_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
        .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
        .pslverr_o(pslverr_o), .hw_watchdog_i(hw_watchdog_i),
        .halt_reset_option_i(halt_reset_option_i), .halt_i(halt_i),
        .wake_i(wake_i), .wdg_reset_n_o(wdg_reset_n_o));

    // ------------------------------------------------------------------
    // clock, cycle count and helpers
    // ------------------------------------------------------------------
    initial begin
        forever #2.5 mclk_i = ~mclk_i;
    end
    always @(posedge mclk_i) cyc <= cyc + 1;

    task automatic end_sim();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // one apb transfer; request held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int i;
        @(posedge mclk_i);
        psel_i    <= 1'b1;
        pwrite_i  <= w;
        paddr_i   <= a;
        pwdata_i  <= d;
        @(posedge mclk_i);
        penable_i <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge mclk_i);
            if (pready_o === 1'b1) break;
        end
        if (i == 20) begin
            $display("BAD pready expected 1 seen 0");
            num_errors++;
            end_sim();
        end
        rd = prdata_o;
        er = pslverr_o;
        psel_i    <= 1'b0;
        penable_i <= 1'b0;
        tw = cyc;
    endtask

    // waits for a reset pulse, then measures its length
    task automatic expect_rst(input int bound);
        int i;
        for (i = 0; i < bound; i++) begin
            @(negedge mclk_i);
            if (wdg_reset_n_o === 1'b0) break;
        end
        if (i == bound) begin
            $display("BAD reset expected 0 seen 1 for %0d cycles", bound);
            num_errors++;
            end_sim();
        end
        tf = cyc;
        len = 0;
        while (wdg_reset_n_o === 1'b0 && len < 200) begin
            len++;
            @(negedge mclk_i);
        end
        chk("pulse length", len, WWD_RST_CYC);
    endtask

    task automatic quiet(input int n);
        int lo;
        lo = 0;
        repeat (n) begin
            @(negedge mclk_i);
            if (wdg_reset_n_o !== 1'b1) lo++;
        end
        chk("no reset", lo, 0);
    endtask

    // one-cycle strobe on halt (h=1) or wake (h=0)
    task automatic strobe(input logic h);
        @(posedge mclk_i);
        halt_i <= h;
        wake_i <= ~h;
        @(posedge mclk_i);
        halt_i <= 1'b0;
        wake_i <= 1'b0;
    endtask

    task automatic do_reset();
        @(posedge mclk_i);
        arst_n_i <= 1'b0;
        repeat (16) @(posedge mclk_i);
        arst_n_i <= 1'b1;
    endtask

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        do_reset();
        apb(1'b0, WWD_CTRL_OFS, 32'h00000000);
        chk("ctrl reset", rd, 32'h0000007F);
        apb(1'b0, WWD_STAT_OFS, 32'h00000000);
        chk("status reset", rd, 32'h00000000);
        apb(1'b0, 12'h008, 32'h00000000);
        chk("unmapped err", {31'h0, er}, 32'h00000001);
        chk("unmapped data", rd, 32'h00000000);
        // rollover while inactive must stay silent
        apb(1'b1, WWD_CTRL_OFS, 32'h00000041);
        quiet(4 * PC);
        // two steps left once active
        apb(1'b1, WWD_CTRL_OFS, 32'h000000C1);
        expect_rst(3 * PC);
        chk("two steps", (tf - tw > PC) && (tf - tw <= 2 * PC + 3), 1);
        // prescaler phase is not reset by the write
        t1 = tf;
        apb(1'b1, WWD_CTRL_OFS, 32'h000000C0);
        expect_rst(8 * PC);
        chk("tick spacing", tf - t1, 7 * PC);
        apb(1'b1, WWD_CTRL_OFS, 32'h0000007F);
        apb(1'b0, WWD_CTRL_OFS, 32'h00000000);
        chk("act sticky", rd & 32'h00000080, 32'h00000080);
        apb(1'b1, WWD_CTRL_OFS, 32'h000000BF);
        expect_rst(3);
        apb(1'b1, WWD_CTRL_OFS, 32'h000000FF);
        halt_reset_option_i <= 1'b1;
        strobe(1'b1);
        expect_rst(4);
        do_reset();
        apb(1'b0, WWD_CTRL_OFS, 32'h00000000);
        chk("ctrl after reset", rd, 32'h0000007F);
        // halt without reset option freezes until wake plus delay
        halt_reset_option_i <= 1'b0;
        apb(1'b1, WWD_CTRL_OFS, 32'h000000FF);
        strobe(1'b1);
        apb(1'b0, WWD_STAT_OFS, 32'h00000000);
        chk("halted", rd, 32'h00000009);
        apb(1'b0, WWD_CTRL_OFS, 32'h00000000);
        v = rd;
        quiet(4 * PC);
        apb(1'b0, WWD_CTRL_OFS, 32'h00000000);
        chk("frozen", rd, v);
        strobe(1'b0);
        apb(1'b0, WWD_STAT_OFS, 32'h00000000);
        chk("waking", rd, 32'h0000000A);
        repeat (WC) @(posedge mclk_i);
        apb(1'b0, WWD_STAT_OFS, 32'h00000000);
        chk("running", rd, 32'h00000008);
        // hardware option ignores the activation bit
        do_reset();
        hw_watchdog_i <= 1'b1;
        apb(1'b1, WWD_CTRL_OFS, 32'h00000041);
        expect_rst(2 * PC + 4);
        hw_watchdog_i <= 1'b0;
        end_sim();
    end
endmodule
